// >>> wbd_top.v
// Device-side interpreter for write-buffer and write-DMA commands.
`timescale 1ns/1ps
`include "wbd_defs.vh"
module wbd_top (
   input wire clk_i,
   input wire nrst_i,
   input wire [2:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [15:0] rdata_o,
   output wire dmarq_o,
   input wire dma_wr_i,
   input wire [15:0] dma_data_i,
   output wire intrq_o,
   output wire med_valid_o,
   output wire [15:0] med_word_o,
   input wire med_ready_i,
   output wire [27:0] med_addr_o,
   output wire med_lba_o,
   input wire med_done_i,
   input wire med_crc_i,
   input wire med_idnf_i
);
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_XFER = 3'b010;
   localparam [2:0] S_MWAIT = 3'b100;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.
   ////////////////////////////////////////////////////////////////////////

   // Sector count field to number of sectors.
   function [8:0] wbd_sects;
      input [7:0] sc;
      begin
         if (sc == 8'h00) begin
            wbd_sects = 9'h100;
         end else begin
            wbd_sects = {1'b0, sc};
         end
      end
   endfunction

   // Position after the given one, as head, cylinder and sector fields.
   function [27:0] wbd_next_addr;
      input lba;
      input [27:0] a;
      reg [7:0] s;
      reg [15:0] c;
      reg [3:0] h;
      begin
         s = a[7:0];
         c = a[23:8];
         h = a[27:24];
         if (lba) begin
            wbd_next_addr = a + 28'h0000001;
         end else if (s != `WBD_SPT) begin
            wbd_next_addr = {h, c, s + 8'h01};
         end else if (h != `WBD_HEAD_LAST) begin
            wbd_next_addr = {h + 4'h1, c, 8'h01};
         end else begin
            wbd_next_addr = {4'h0, c + 16'h0001, 8'h01};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State.
   ////////////////////////////////////////////////////////////////////////

   reg [2:0] st_q;
   reg busy_q;
   reg dma_q;
   reg med_q;
   reg err_q;
   reg [7:0] errreg_q;
   reg drq_q;
   reg dmarq_q;
   reg intrq_q;
   reg [7:0] sc_q;
   reg [7:0] sn_q;
   reg [7:0] cl_q;
   reg [7:0] ch_q;
   reg [7:0] dh_q;
   reg [8:0] rem_q;
   reg [16:0] in_left_q;
   reg [7:0] wcnt_q;
   reg [7:0] rptr_q;
   reg [15:0] rdata_q;
   reg med_v_q;
   reg [15:0] med_w_q;

   reg push;
   reg [15:0] push_data;
   reg f_rdy;
   reg fin;
   reg [7:0] fin_eb;
   reg [16:0] left_nx;
   reg room;
   reg [7:0] rptr_d;

   wire f_in_rdy;
   wire f_v;
   wire [15:0] f_dat;
   wire [15:0] buf_dout;
   wire pop;
   wire last_pop;
   wire go;
   wire [7:0] status;
   wire cmd_wr;
   wire data_wr;
   wire data_rd;
   wire start;
   wire is_wbuf;
   wire is_wbufd;
   wire is_wdma;
   wire [8:0] sc_eff;
   wire [27:0] cur_addr;

   assign cmd_wr = wr_i & (addr_i == `WBD_A_STACMD);
   assign data_wr = wr_i & (addr_i == `WBD_A_DATA);
   assign data_rd = rd_i & (addr_i == `WBD_A_DATA) & ~busy_q;
   assign start = cmd_wr & ~busy_q;
   assign is_wbuf = wdata_i[7:0] == `WBD_CMD_WBUF;
   assign is_wbufd = wdata_i[7:0] == `WBD_CMD_WBUFDMA;
   assign is_wdma = wdata_i[7:1] == `WBD_CMD_WDMA;
   assign sc_eff = wbd_sects(sc_q);
   assign cur_addr = {dh_q[3:0], ch_q, cl_q, sn_q};
   assign pop = f_v & f_rdy;
   assign last_pop = pop & (wcnt_q == `WBD_LAST_WORD);
   assign go = busy_q & ~fin;

   // Busy, ready, fault, seek done, data request, corrected, index, error.
   assign status = {busy_q, 1'b1, 1'b0, 1'b1, drq_q, 1'b0, 1'b0, err_q};

   assign rdata_o = rdata_q;
   assign dmarq_o = dmarq_q;
   assign intrq_o = intrq_q;
   assign med_valid_o = med_v_q;
   assign med_word_o = med_w_q;
   assign med_addr_o = cur_addr;
   assign med_lba_o = dh_q[`WBD_DH_LBA];

   ////////////////////////////////////////////////////////////////////////
   // Data path: host words enter the buffer, then the sector store or media.
   ////////////////////////////////////////////////////////////////////////

   wbd_fifo2 u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .flush_i(fin),
      .in_valid_i(push),
      .in_data_i(push_data),
      .in_ready_o(f_in_rdy),
      .out_valid_o(f_v),
      .out_data_o(f_dat),
      .out_ready_i(f_rdy)
   );

   wbd_sbuf u_sbuf (
      .clk_i(clk_i),
      .we_i(pop & ~med_q),
      .waddr_i(wcnt_q),
      .wdata_i(f_dat),
      .raddr_i(rptr_d),
      .rdata_o(buf_dout)
   );

   always @* begin
      push = 1'b0;
      push_data = wdata_i;
      if (drq_q && data_wr && f_in_rdy) begin
         push = 1'b1;
      end else if (dmarq_q && dma_wr_i && f_in_rdy) begin
         push = 1'b1;
         push_data = dma_data_i;
      end
      // A media write stalls the drain while the output word waits.
      if (st_q == S_XFER) begin
         f_rdy = med_q ? (~med_v_q | med_ready_i) : 1'b1;
      end else begin
         f_rdy = 1'b0;
      end
      fin = 1'b0;
      fin_eb = 8'h00;
      if (st_q == S_XFER && last_pop && !med_q) begin
         fin = 1'b1;
      end
      if (st_q == S_MWAIT && med_done_i) begin
         if (med_crc_i || med_idnf_i) begin
            fin = 1'b1;
            fin_eb[`WBD_ER_CRC] = med_crc_i;
            fin_eb[`WBD_ER_IDN] = med_idnf_i;
         end else if (rem_q == 9'h001) begin
            fin = 1'b1;
         end
      end
      left_nx = in_left_q - {16'h0000, push};
      // No word is requested that the buffer could not take next cycle.
      room = f_in_rdy & ~(f_v & push & ~pop);
      if (start && is_wbuf) begin
         rptr_d = 8'h00;
      end else if (data_rd) begin
         rptr_d = rptr_q + 8'h01;
      end else begin
         rptr_d = rptr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port reads.
   ////////////////////////////////////////////////////////////////////////

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q <= 16'h0000;
         rptr_q <= 8'h00;
      end else begin
         rptr_q <= rptr_d;
         if (rd_i) begin
            case (addr_i)
               `WBD_A_DATA: rdata_q <= busy_q ? 16'h0000 : buf_dout;
               `WBD_A_ERRFEAT: rdata_q <= {8'h00, errreg_q};
               `WBD_A_SCNT: rdata_q <= {8'h00, sc_q};
               `WBD_A_SNUM: rdata_q <= {8'h00, sn_q};
               `WBD_A_CYLL: rdata_q <= {8'h00, cl_q};
               `WBD_A_CYLH: rdata_q <= {8'h00, ch_q};
               `WBD_A_DRVHD: rdata_q <= {8'h00, dh_q};
               default: rdata_q <= {8'h00, status};
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer.
   ////////////////////////////////////////////////////////////////////////

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         st_q <= S_IDLE;
         busy_q <= 1'b0;
         dma_q <= 1'b0;
         med_q <= 1'b0;
         err_q <= 1'b0;
         errreg_q <= 8'h00;
         drq_q <= 1'b0;
         dmarq_q <= 1'b0;
         intrq_q <= 1'b0;
         sc_q <= `WBD_SC_RST;
         sn_q <= `WBD_SN_RST;
         cl_q <= `WBD_CYL_RST;
         ch_q <= `WBD_CYL_RST;
         dh_q <= `WBD_DH_RST;
         rem_q <= 9'h000;
         in_left_q <= 17'h00000;
         wcnt_q <= 8'h00;
         med_v_q <= 1'b0;
         med_w_q <= 16'h0000;
      end else begin
         // Reading status acknowledges the pending interrupt.
         if (rd_i && addr_i == `WBD_A_STACMD) begin
            intrq_q <= 1'b0;
         end
         // The task file is only writable while idle.
         if (wr_i && !busy_q) begin
            case (addr_i)
               `WBD_A_SCNT: sc_q <= wdata_i[7:0];
               `WBD_A_SNUM: sn_q <= wdata_i[7:0];
               `WBD_A_CYLL: cl_q <= wdata_i[7:0];
               `WBD_A_CYLH: ch_q <= wdata_i[7:0];
               `WBD_A_DRVHD: dh_q <= wdata_i[7:0];
               default: ;
            endcase
         end
         if (push) begin
            in_left_q <= left_nx;
         end
         if (med_v_q && med_ready_i) begin
            med_v_q <= 1'b0;
         end
         case (st_q)
            S_IDLE: begin
               if (start) begin
                  intrq_q <= 1'b0;
                  if (is_wbuf || is_wbufd || is_wdma) begin
                     st_q <= S_XFER;
                     busy_q <= 1'b1;
                     dma_q <= ~is_wbuf;
                     med_q <= is_wdma;
                     err_q <= 1'b0;
                     errreg_q <= 8'h00;
                     wcnt_q <= 8'h00;
                     drq_q <= is_wbuf;
                     dmarq_q <= ~is_wbuf;
                     if (is_wdma) begin
                        rem_q <= sc_eff;
                        in_left_q <= {sc_eff, 8'h00};
                     end else begin
                        rem_q <= 9'h001;
                        in_left_q <= `WBD_SECT_WORDS;
                     end
                  end else begin
                     err_q <= 1'b1;
                     errreg_q <= 8'h01 << `WBD_ER_ABT;
                     intrq_q <= 1'b1;
                  end
               end
            end
            S_XFER: begin
               if (pop) begin
                  wcnt_q <= wcnt_q + 8'h01;
                  if (med_q) begin
                     med_v_q <= 1'b1;
                     med_w_q <= f_dat;
                  end
               end
               if (last_pop && med_q) begin
                  st_q <= S_MWAIT;
               end
            end
            S_MWAIT: begin
               if (med_done_i && !fin) begin
                  rem_q <= rem_q - 9'h001;
                  {dh_q[3:0], ch_q, cl_q, sn_q} <=
                     wbd_next_addr(dh_q[`WBD_DH_LBA], cur_addr);
                  st_q <= S_XFER;
               end
            end
            default: st_q <= S_IDLE;
         endcase
         if (busy_q) begin
            dmarq_q <= go & dma_q & (left_nx != 17'h00000) & room;
            drq_q <= go & ~dma_q & (left_nx != 17'h00000) & room;
         end
         if (fin) begin
            st_q <= S_IDLE;
            busy_q <= 1'b0;
            intrq_q <= 1'b1;
            med_v_q <= 1'b0;
            errreg_q <= fin_eb;
            err_q <= |fin_eb;
            if (med_q) begin
               sc_q <= (|fin_eb) ? rem_q[7:0] : 8'h00;
            end
         end
      end
   end

   // Address registers already hold the last transferred position at the
   // end, since they only advance when another sector follows.

endmodule // wbd_top

// >>> wbd_defs.vh
// Constants for the ATA write-buffer and write-DMA command block.
// What this block does
// - E8h takes one sector into buffer.
// - EBh takes one sector into buffer by DMA.
// - Buffer writes and reads share one 512-byte region.
// - Payload moves as 16-bit words.
// - CAh/CBh receive sectors, then commit to media.
// - DMA request paces every DMA word.
// - One interrupt after transfer end and status.
// - Media error stops write at failing sector.
// - Sector count zero means 256 sectors.
// - Sector number: first sector or address 0-7.
// - Cylinder registers: cylinder or address 8-23.
// - Head field: head or address 24-27.
// - Low command bit is ignored for CAh/CBh.
// - Sector count returns sectors not transferred.
// - Sector number returns last transferred position.
// - Cylinder registers return last transferred position.
// - Head field returns last transferred position.
`ifndef WBD_DEFS_VH
`define WBD_DEFS_VH

// Task-file offsets on the register port.
`define WBD_A_DATA 3'h0
`define WBD_A_ERRFEAT 3'h1
`define WBD_A_SCNT 3'h2
`define WBD_A_SNUM 3'h3
`define WBD_A_CYLL 3'h4
`define WBD_A_CYLH 3'h5
`define WBD_A_DRVHD 3'h6
`define WBD_A_STACMD 3'h7

// Command codes; the DMA write code is compared without its low bit.
`define WBD_CMD_WBUF 8'he8
`define WBD_CMD_WBUFDMA 8'heb
`define WBD_CMD_WDMA 7'h65

// Error register bit positions.
`define WBD_ER_CRC 7
`define WBD_ER_IDN 4
`define WBD_ER_ABT 2

// Drive/head register bit positions.
`define WBD_DH_LBA 6

// Reset values of the task file.
`define WBD_DH_RST 8'ha0
`define WBD_SC_RST 8'h01
`define WBD_SN_RST 8'h01
`define WBD_CYL_RST 8'h00

// Sector geometry: 256 words of 16 bits per sector.
`define WBD_LAST_WORD 8'hff
`define WBD_SECT_WORDS 17'h00100
`define WBD_SPT 8'h3f
`define WBD_HEAD_LAST 4'hf

`endif

// >>> wbd_sbuf.v
// Sector buffer memory of 256 16-bit words with registered read data.
`timescale 1ns/1ps
module wbd_sbuf (
   input wire clk_i,
   input wire we_i,
   input wire [7:0] waddr_i,
   input wire [15:0] wdata_i,
   input wire [7:0] raddr_i,
   output reg [15:0] rdata_o
);
   reg [15:0] mem [0:255];

   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // wbd_sbuf

// >>> wbd_fifo2.v
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps
module wbd_fifo2 (
   input wire clk_i,
   input wire nrst_i,
   input wire flush_i,
   input wire in_valid_i,
   input wire [15:0] in_data_i,
   output wire in_ready_o,
   output wire out_valid_o,
   output wire [15:0] out_data_o,
   input wire out_ready_i
);
   reg [15:0] head_q;
   reg [15:0] tail_q;
   reg head_v_q;
   reg tail_v_q;
   wire push;
   wire pop;

   assign in_ready_o = ~tail_v_q;
   assign out_valid_o = head_v_q;
   assign out_data_o = head_q;
   assign push = in_valid_i & ~tail_v_q;
   assign pop = head_v_q & out_ready_i;

   always @(posedge clk_i) begin
      if (!nrst_i || flush_i) begin
         head_q <= 16'h0000;
         tail_q <= 16'h0000;
         head_v_q <= 1'b0;
         tail_v_q <= 1'b0;
      end else if (pop) begin
         if (tail_v_q) begin
            head_q <= tail_q;
            tail_v_q <= 1'b0;
         end else begin
            head_q <= in_data_i;
            head_v_q <= push;
         end
      end else if (push) begin
         if (!head_v_q) begin
            head_q <= in_data_i;
            head_v_q <= 1'b1;
         end else begin
            tail_q <= in_data_i;
            tail_v_q <= 1'b1;
         end
      end
   end
endmodule // wbd_fifo2

// >>> wbd_top_asserts.sv
// Port-level assertions for the write command interpreter.
`timescale 1ns/1ps
module wbd_top_asserts (
   input wire clk_i,
   input wire nrst_i,
   input wire [2:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   input wire dmarq_o,
   input wire intrq_o,
   input wire med_valid_o,
   input wire [15:0] med_word_o,
   input wire med_ready_i,
   input wire [27:0] med_addr_o,
   input wire med_lba_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   reg idle_q;
   wire stat_rd = rd_i && addr_i == 3'h7;
   wire cmd_wr = wr_i && addr_i == 3'h7;
   // Tracks command activity as seen from the ports alone.
   always @(posedge clk_i) begin
      if (!nrst_i)
         idle_q <= 1'b1;
      else if (cmd_wr && idle_q)
         idle_q <= 1'b0;
      else if (intrq_o)
         idle_q <= 1'b1;
   end
   a_media_hold: assert property (med_valid_o && !med_ready_i
      |=> med_valid_o && $stable(med_word_o))
      else $error("media word lost while stalled");
   a_irq_rd_clear: assert property (stat_rd && intrq_o |=> !intrq_o)
      else $error("status read left interrupt set");
   a_irq_holds: assert property (
      intrq_o && !stat_rd && !cmd_wr |=> intrq_o)
      else $error("interrupt dropped without cause");
   a_irq_no_xfer: assert property (
      intrq_o |-> !dmarq_o && !med_valid_o)
      else $error("interrupt raised while data still moves");
   a_req_busy: assert property (dmarq_o |-> !idle_q)
      else $error("dma request outside a command");
   a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data changed without a read");
   a_lba_load: assert property (
      idle_q && wr_i && addr_i == 3'h6
      |-> ##2 med_lba_o == $past(wdata_i[6], 2))
      else $error("addressing mode not taken from drive/head");
   a_snum_load: assert property (
      idle_q && wr_i && addr_i == 3'h3
      |-> ##2 med_addr_o[7:0] == $past(wdata_i[7:0], 2))
      else $error("start position not taken from sector number");
   cover property ($rose(intrq_o));
   cover property (med_valid_o && !med_ready_i);
   cover property (dmarq_o ##1 !dmarq_o);
endmodule // wbd_top_asserts

bind wbd_top wbd_top_asserts u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .dmarq_o(dmarq_o), .intrq_o(intrq_o),
   .med_valid_o(med_valid_o), .med_word_o(med_word_o),
   .med_ready_i(med_ready_i), .med_addr_o(med_addr_o),
   .med_lba_o(med_lba_o));

// >>> wbd_host_dma.sv
// Host slave-DMA channel model that feeds words while requested.
`timescale 1ns/1ps
module wbd_host_dma (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic slow_i,
   input wire logic dmarq_i,
   output logic dma_wr_o,
   output logic [16:0] n_o,
   output logic [15:0] dma_data_o
);
   initial begin
      dma_wr_o = 1'b0;
      n_o = 17'h00000;
   end
   // Word k is k xor a pattern; inverted while no strobe is driven.
   assign dma_data_o = n_o[15:0] ^ 16'ha5c3 ^ {16{!dma_wr_o}};
   always @(posedge clk_i) begin
      if (!en_i) begin
         dma_wr_o <= 1'b0;
         n_o <= 17'h00000;
      end else if (dma_wr_o && dmarq_i) begin
         n_o <= n_o + 17'h00001;
         dma_wr_o <= dmarq_i && !slow_i;
      end else begin
         dma_wr_o <= dmarq_i;
      end
   end
endmodule // wbd_host_dma

// >>> tb_wbd_top.sv
// Self-checking bench for the write command interpreter.
`timescale 1ns/1ps
module tb_wbd_top;
   typedef struct {
      logic [7:0] cmd, cnt, sn0, st, er, rc, sn, cl, dh;
      logic lba;
      int fail, fk;
   } wbd_row_t;
   wbd_row_t rows[6] = '{
      '{8'hca, 8'h03, 8'hfe, 8'h50, 8'h00, 8'h00, 8'h00, 8'h35, 8'he5, 1, -1, 0},
      '{8'hcb, 8'h03, 8'hfe, 8'h51, 8'h80, 8'h02, 8'hff, 8'h34, 8'he5, 1, 1, 1},
      '{8'hcb, 8'h02, 8'h3f, 8'h50, 8'h00, 8'h00, 8'h01, 8'h34, 8'ha6, 0, -1, 0},
      '{8'hca, 8'h01, 8'hfe, 8'h51, 8'h10, 8'h01, 8'hfe, 8'h34, 8'he5, 1, 0, 2},
      '{8'hca, 8'h00, 8'hfe, 8'h51, 8'h80, 8'hff, 8'hff, 8'h34, 8'he5, 1, 1, 1},
      '{8'h99, 8'h01, 8'hfe, 8'h51, 8'h04, 8'h01, 8'hfe, 8'h34, 8'he5, 1, -1, 0}};
   wbd_row_t r;
   logic [7:0] e[7];
   logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, med_ready_i = 0;
   logic med_done_i = 0, med_crc_i = 0, med_idnf_i = 0, dma_en = 0;
   logic slow = 0, dmarq_o, dma_wr_i, intrq_o, med_valid_o, med_lba_o;
   logic [2:0] addr_i = 0;
   logic [15:0] wdata_i = 0, rdata_o, dma_data_i, med_word_o;
   logic [16:0] nw;
   logic [27:0] med_addr_o;
   int n_errors = 0, n_compared = 0, mw = 0, mt = 0, m0, sec = 0;
   int fail = -1, fkind = 0;
   wbd_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .dmarq_o(dmarq_o), .dma_wr_i(dma_wr_i), .dma_data_i(dma_data_i),
      .intrq_o(intrq_o), .med_valid_o(med_valid_o),
      .med_word_o(med_word_o), .med_ready_i(med_ready_i),
      .med_addr_o(med_addr_o), .med_lba_o(med_lba_o),
      .med_done_i(med_done_i), .med_crc_i(med_crc_i),
      .med_idnf_i(med_idnf_i));
   wbd_host_dma host (.clk_i(clk_i), .en_i(dma_en), .slow_i(slow),
      .dmarq_i(dmarq_o), .dma_wr_o(dma_wr_i), .n_o(nw),
      .dma_data_o(dma_data_i));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic end_sim;
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic op(input logic w, rr, input logic [2:0] a,
      input logic [15:0] d);
      wr_i <= w;
      rd_i <= rr;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [2:0] a, input logic [15:0] x);
      op(0, 1, a, 16'h0000);
      #1;
      chk(rdata_o & (a == 3'h0 ? 16'hffff : 16'h00ff), x, "read");
   endtask
   task automatic regs(input int first);
      for (int a = first; a < 8; a++)
         rdchk(a[2:0], {8'h00, e[a - 1]});
   endtask
   task automatic wirq;
      for (int i = 0; i < 20000 && intrq_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk({15'h0000, intrq_o}, 16'h0001, "interrupt");
   endtask
   // Media side: stalls every other cycle and checks each word it takes.
   always @(posedge clk_i) begin
      med_ready_i <= !med_ready_i;
      med_done_i <= dma_en && med_valid_o && med_ready_i && mw[7:0] == 8'hff;
      med_crc_i <= sec == fail && fkind == 1;
      med_idnf_i <= sec == fail && fkind == 2;
      if (med_valid_o && med_ready_i) begin
         mt <= mt + 1;
         chk(med_word_o, mw[15:0] ^ 16'ha5c3, "media word");
      end
      if (!dma_en) begin
         mw <= 0;
         sec <= 0;
      end else if (med_valid_o && med_ready_i) begin
         mw <= mw + 1;
         if (mw[7:0] == 8'hff)
            sec <= sec + 1;
      end
   end
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         slow <= i[0];
         op(1, 0, 3'h2, {8'h00, r.cnt});
         op(1, 0, 3'h3, {8'h00, r.sn0});
         op(1, 0, 3'h4, 16'h0034);
         op(1, 0, 3'h5, 16'h0012);
         op(1, 0, 3'h6, {9'h001, r.lba, 6'h25});
         fail = r.fail;
         fkind = r.fk;
         dma_en <= 1'b1;
         op(1, 0, 3'h7, {8'h00, r.cmd});
         op(0, 0, 3'h0, 16'h0000);
         wirq();
         if (r.fk == 0)
            chk(nw[15:0], {r.cnt - r.rc, 8'h00}, "dma words");
         e = '{r.er, r.rc, r.sn, r.cl, 8'h12, r.dh, r.st};
         regs(1);
         dma_en <= 1'b0;
      end
      m0 = mt;
      op(1, 0, 3'h7, 16'h00e8);
      for (int k = 0; k < 256; k++)
         op(1, 0, 3'h0, 16'h1e00 ^ k[15:0]);
      op(0, 0, 3'h0, 16'h0000);
      wirq();
      rdchk(3'h7, 16'h0050);
      for (int k = 0; k < 256; k++)
         rdchk(3'h0, 16'h1e00 ^ k[15:0]);
      slow <= 1'b1;
      dma_en <= 1'b1;
      op(1, 0, 3'h7, 16'h00eb);
      op(0, 0, 3'h0, 16'h0000);
      wirq();
      chk(nw[15:0], 16'h0100, "dma words");
      dma_en <= 1'b0;
      chk(mt[15:0] - m0[15:0], 16'h0000, "media idle");
      for (int k = 0; k < 256; k++)
         rdchk(3'h0, 16'ha5c3 ^ k[15:0]);
      op(0, 0, 3'h0, 16'h0000);
      nrst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      e = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h50};
      regs(2);
      chk({15'h0000, intrq_o}, 16'h0000, "interrupt idle");
      end_sim();
   end
endmodule // tb_wbd_top
